// >>> src/otp_pkg.sv
// Package for the one-time-programmable region block.
// Holds opcodes, the region address map, register offsets, timing counts and carrier types.
package otp_pkg;

    // ----------------------------------------------------------------
    // Serial commands
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_ONE_TIME_PROGRAM = 8'h42;
    localparam logic [7:0] OP_ONE_TIME_READ = 8'h4B;

    // ----------------------------------------------------------------
    // Address map: absolute bounds of the space, then offsets from its first byte
    // ----------------------------------------------------------------
    localparam int OTP_BYTES = 512;
    localparam logic [23:0] OTP_BASE = 24'h00_0100;
    localparam logic [23:0] OTP_LAST = 24'h00_02FF;
    localparam logic [8:0] LOCK_SERIAL_IDX = 9'h000;
    localparam logic [8:0] RESERVED_IDX = 9'h001;
    localparam logic [8:0] FACTORY_SERIAL_IDX = 9'h002;
    localparam logic [8:0] CUSTOMER_SERIAL_IDX = 9'h00A;
    localparam logic [8:0] LOCK_FIRST_IDX = 9'h012;
    localparam logic [8:0] USER_FIRST_IDX = 9'h014;
    localparam logic [8:0] LOCK_SECOND_IDX = 9'h114;
    localparam logic [8:0] USER_SECOND_IDX = 9'h116;
    localparam logic [8:0] USER_SHORT_IDX = 9'h1F6;
    localparam logic [7:0] LOCK_SERIAL_MASK = 8'h03;
    localparam logic [7:0] LOCK_SECOND_HI_MASK = 8'h7F;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // ----------------------------------------------------------------
    // Timing: program time at normal speed
    // ----------------------------------------------------------------
    localparam int SYS_CLK_HZ = 25_000_000;
    localparam int PROG_TIME_US = 100;
    localparam int PROG_CYCLES = (PROG_TIME_US * (SYS_CLK_HZ / 1_000_000));
    localparam logic [11:0] PROG_COUNT = 12'(PROG_CYCLES);

    // ----------------------------------------------------------------
    // Register bus offsets and fields
    // ----------------------------------------------------------------
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h04;
    localparam logic [4:0] REG_SERIAL_LO = 5'h08;
    localparam logic [4:0] REG_SERIAL_HI = 5'h0C;
    localparam int CTRL_PROVISION_BIT = 0;
    localparam int CTRL_CLEAR_REFUSED_BIT = 1;
    localparam logic [31:0] SERIAL_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [4:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } bus_req_t;

    typedef struct packed {
        logic sclk;
        logic csN;
        logic si;
        logic hwResetN;
    } spi_pins_t;

endpackage

// >>> src/otp_region_access.sv
// Top of the one-time-programmable region block of a serial flash.
// Assumes mode-0 serial pins from a host, a main-array busy level on sys_clk, and an Avalon master.
`timescale 1ns/1ns

module otp_region_access (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Serial pins from the host
    input wire otp_pkg::spi_pins_t spiPins,
    output logic serialOut,
    output logic serialOutEn,
    // Main-array engine
    input wire logic mainBusy,
    // Avalon-MM slave
    input wire otp_pkg::bus_req_t avs,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        S_IDLE = 7'b000_0001,
        S_OPCODE = 7'b000_0010,
        S_ADDR = 7'b000_0100,
        S_DUMMY = 7'b000_1000,
        S_DATA_IN = 7'b001_0000,
        S_DATA_OUT = 7'b010_0000,
        S_IGNORE = 7'b100_0000
    } spi_state_t;

    typedef struct packed {
        spi_state_t state;
        logic [2:0] bitCnt;
        logic [1:0] byteCnt;
        logic [1:0] dataCnt;
        logic [7:0] shiftIn;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [7:0] dataByte;
        logic [7:0] shiftOut;
        logic soData;
        logic sclkPrev;
        logic csPrevN;
        logic wel;
        logic wip;
        logic [11:0] progTimer;
        logic [8:0] progIdx;
        logic [7:0] progByte;
        logic otpMode;
        logic refused;
        logic busAck;
        logic [31:0] readData;
        logic [31:0] serialLo;
        logic [31:0] serialHi;
        logic [otp_pkg::OTP_BYTES-1:0][7:0] mem;
    } top_state_t;

    top_state_t st_reg;
    top_state_t st_next;
    otp_pkg::spi_pins_t pinF;
    logic [7:0] progMask;
    logic [7:0] inByte;
    logic sclkRise;
    logic sclkFall;
    logic frameStart;
    logic frameEnd;
    logic addrValid;
    logic [8:0] addrIdx;
    logic [7:0] statusByte;
    logic [7:0] outByte;
    logic otpBlocked;
    logic [63:0] serialWord;

    // ----------------------------------------------------------------
    // Pin synchronisers and region map
    // ----------------------------------------------------------------
    pin_sync #(
        .W(4),
        .RST_VAL(4'b0101)
    ) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .pinIn(spiPins),
        .pinOut(pinF)
    );

    otp_region_map u_map (
        .offset(addrIdx),
        .lockSerial(st_reg.mem[otp_pkg::LOCK_SERIAL_IDX]),
        .lockFirst({st_reg.mem[otp_pkg::LOCK_FIRST_IDX + 9'h001],
            st_reg.mem[otp_pkg::LOCK_FIRST_IDX]}),
        .lockSecond({st_reg.mem[otp_pkg::LOCK_SECOND_IDX + 9'h001],
            st_reg.mem[otp_pkg::LOCK_SECOND_IDX]}),
        .writeMask(progMask)
    );

    // ----------------------------------------------------------------
    // Decoded events
    // ----------------------------------------------------------------
    assign sclkRise = pinF.sclk && !st_reg.sclkPrev && !pinF.csN;
    assign sclkFall = !pinF.sclk && st_reg.sclkPrev && !pinF.csN;
    assign frameStart = !pinF.csN && st_reg.csPrevN;
    assign frameEnd = pinF.csN && !st_reg.csPrevN;
    assign inByte = {st_reg.shiftIn[6:0], pinF.si};
    assign addrValid = (st_reg.addr >= otp_pkg::OTP_BASE) && (st_reg.addr <= otp_pkg::OTP_LAST);
    assign addrIdx = 9'(st_reg.addr - otp_pkg::OTP_BASE);
    assign statusByte = {6'b00_0000, st_reg.wel, st_reg.wip || mainBusy};
    assign otpBlocked = st_reg.wip || mainBusy;
    assign serialWord = {st_reg.serialHi, st_reg.serialLo};
    // Out-of-range reads give all ones; the host may not rely on it.
    assign outByte = (st_reg.opcode == otp_pkg::OP_READ_STATUS) ? statusByte :
        (addrValid ? st_reg.mem[addrIdx] : otp_pkg::ERASED_BYTE);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.sclkPrev = pinF.sclk;
        st_next.csPrevN = pinF.csN;

        // Software clear of the refused flag; a refusal in the same cycle still wins.
        if (avs.write && st_reg.busAck && avs.address == otp_pkg::REG_CTRL
            && avs.byteenable[0] && avs.writedata[otp_pkg::CTRL_CLEAR_REFUSED_BIT])
            st_next.refused = 1'b0;

        // Serial frame handling.
        if (frameStart)
        begin
            st_next.state = S_OPCODE;
            st_next.bitCnt = '0;
            st_next.byteCnt = '0;
            st_next.dataCnt = '0;
        end
        else if (frameEnd)
        begin
            if (st_reg.state == S_DATA_IN && st_reg.opcode == otp_pkg::OP_ONE_TIME_PROGRAM
                && st_reg.dataCnt == 2'd1 && st_reg.bitCnt == 3'd0
                && st_reg.wel && addrValid && !otpBlocked)
            begin
                st_next.wip = 1'b1;
                st_next.wel = 1'b0;
                st_next.progTimer = otp_pkg::PROG_COUNT;
                st_next.progIdx = addrIdx;
                // A one in the data or a locked bit keeps the stored value.
                st_next.progByte = st_reg.mem[addrIdx] & (st_reg.dataByte | ~progMask);
            end
            st_next.state = S_IDLE;
            st_next.otpMode = 1'b0;
        end
        else if (sclkRise)
        begin
            st_next.shiftIn = inByte;
            st_next.bitCnt = st_reg.bitCnt + 3'd1;
            case (st_reg.state)
                S_OPCODE:
                begin
                    if (st_reg.bitCnt == 3'd7)
                    begin
                        st_next.opcode = inByte;
                        st_next.state = S_IGNORE;
                        if (inByte == otp_pkg::OP_WRITE_ENABLE)
                            st_next.wel = 1'b1;
                        else if (inByte == otp_pkg::OP_WRITE_DISABLE)
                            st_next.wel = 1'b0;
                        else if (inByte == otp_pkg::OP_READ_STATUS)
                        begin
                            st_next.shiftOut = statusByte;
                            st_next.state = S_DATA_OUT;
                        end
                        else if (inByte == otp_pkg::OP_ONE_TIME_PROGRAM
                            || inByte == otp_pkg::OP_ONE_TIME_READ)
                        begin
                            if (otpBlocked)
                                st_next.refused = 1'b1;
                            else
                            begin
                                st_next.otpMode = 1'b1;
                                st_next.state = S_ADDR;
                            end
                        end
                    end
                end
                S_ADDR:
                begin
                    if (st_reg.bitCnt == 3'd7)
                    begin
                        st_next.addr = {st_reg.addr[15:0], inByte};
                        st_next.byteCnt = st_reg.byteCnt + 2'd1;
                        if (st_reg.byteCnt == 2'd2)
                            st_next.state = (st_reg.opcode == otp_pkg::OP_ONE_TIME_READ) ?
                                S_DUMMY : S_DATA_IN;
                    end
                end
                S_DUMMY:
                begin
                    if (st_reg.bitCnt == 3'd7)
                    begin
                        st_next.shiftOut = outByte;
                        st_next.addr = st_reg.addr + 24'd1;
                        st_next.state = S_DATA_OUT;
                    end
                end
                S_DATA_IN:
                begin
                    if (st_reg.bitCnt == 3'd7)
                    begin
                        st_next.dataByte = inByte;
                        if (st_reg.dataCnt != 2'd3)
                            st_next.dataCnt = st_reg.dataCnt + 2'd1;
                    end
                end
                default:
                begin
                end
            endcase
        end
        else if (sclkFall && st_reg.state == S_DATA_OUT)
        begin
            st_next.soData = st_reg.shiftOut[7];
            st_next.shiftOut = {st_reg.shiftOut[6:0], 1'b1};
            if (st_reg.bitCnt == 3'd7)
            begin
                st_next.shiftOut = outByte;
                if (st_reg.opcode == otp_pkg::OP_ONE_TIME_READ)
                    st_next.addr = st_reg.addr + 24'd1;
            end
        end

        // Hardware reset pin drops any frame and returns to normal space.
        if (!pinF.hwResetN)
        begin
            st_next.state = S_IDLE;
            st_next.otpMode = 1'b0;
            st_next.wel = 1'b0;
        end

        // Cell write at the end of the program time; bits only ever clear.
        if (st_reg.wip)
        begin
            st_next.progTimer = st_reg.progTimer - 12'd1;
            if (st_reg.progTimer == 12'd1)
            begin
                st_next.wip = 1'b0;
                st_next.mem[st_reg.progIdx] = st_reg.progByte;
            end
        end

        // Register bus: one wait cycle, then the answer.
        st_next.busAck = (avs.read || avs.write) && !st_reg.busAck;
        if (avs.read && !st_reg.busAck)
        begin
            if (avs.address == otp_pkg::REG_CTRL)
                st_next.readData = 32'h0000_0000;
            else if (avs.address == otp_pkg::REG_STATUS)
                st_next.readData = {st_reg.mem[otp_pkg::LOCK_SERIAL_IDX], 20'h0_0000,
                    st_reg.refused, st_reg.otpMode, st_reg.wel, st_reg.wip || mainBusy};
            else if (avs.address == otp_pkg::REG_SERIAL_LO)
                st_next.readData = st_reg.serialLo;
            else if (avs.address == otp_pkg::REG_SERIAL_HI)
                st_next.readData = st_reg.serialHi;
            else
                st_next.readData = 32'h0000_0000;
        end
        if (avs.write && st_reg.busAck)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (avs.byteenable[b] && avs.address == otp_pkg::REG_SERIAL_LO)
                    st_next.serialLo[b*8 +: 8] = avs.writedata[b*8 +: 8];
                if (avs.byteenable[b] && avs.address == otp_pkg::REG_SERIAL_HI)
                    st_next.serialHi[b*8 +: 8] = avs.writedata[b*8 +: 8];
            end
            if (avs.address == otp_pkg::REG_CTRL && avs.byteenable[0])
            begin
                // Factory provisioning works once, while the lower region is still open.
                if (avs.writedata[otp_pkg::CTRL_PROVISION_BIT]
                    && st_reg.mem[otp_pkg::LOCK_SERIAL_IDX][0] && !st_reg.wip)
                begin
                    for (int k = 0; k < 8; k++)
                        st_next.mem[otp_pkg::FACTORY_SERIAL_IDX + 9'(k)] =
                            serialWord[k*8 +: 8];
                    st_next.mem[otp_pkg::LOCK_SERIAL_IDX][0] = 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_reg <= '0;
            st_reg.state <= S_IDLE;
            st_reg.csPrevN <= 1'b1;
            st_reg.shiftOut <= otp_pkg::ERASED_BYTE;
            st_reg.serialLo <= otp_pkg::SERIAL_RESET;
            st_reg.serialHi <= otp_pkg::SERIAL_RESET;
            st_reg.mem <= {otp_pkg::OTP_BYTES{otp_pkg::ERASED_BYTE}};
        end
        else
            st_reg <= st_next;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign serialOut = st_reg.soData;
    assign serialOutEn = (st_reg.state == S_DATA_OUT) && !pinF.csN;
    assign avsReaddata = st_reg.readData;
    assign avsWaitrequest = (avs.read || avs.write) && !st_reg.busAck;

endmodule // otp_region_access

// >>> src/otp_region_map.sv
// Region map: gives the bits of one OTP byte that a program may still change.
// Assumes the caller has already checked that the offset lies inside the space.
`timescale 1ns/1ns
module otp_region_map (
    // Byte offset into the space
    input wire logic [8:0] offset,
    // Current lock bytes
    input wire logic [7:0] lockSerial,
    input wire logic [15:0] lockFirst,
    input wire logic [15:0] lockSecond,
    // Programmable bits of that byte
    output logic [7:0] writeMask
);

    logic [8:0] rel;
    logic [3:0] region;

    always_comb
    begin
        rel = '0;
        region = '0;
        writeMask = otp_pkg::ERASED_BYTE;
        if (offset == otp_pkg::LOCK_SERIAL_IDX)
            writeMask = otp_pkg::LOCK_SERIAL_MASK;
        else if (offset == otp_pkg::RESERVED_IDX)
            writeMask = 8'h00;
        else if (offset < otp_pkg::CUSTOMER_SERIAL_IDX)
            writeMask = lockSerial[0] ? otp_pkg::ERASED_BYTE : 8'h00;
        else if (offset < otp_pkg::LOCK_FIRST_IDX)
            writeMask = lockSerial[1] ? otp_pkg::ERASED_BYTE : 8'h00;
        else if (offset < otp_pkg::USER_FIRST_IDX)
            writeMask = otp_pkg::ERASED_BYTE;
        else if (offset < otp_pkg::LOCK_SECOND_IDX)
        begin
            rel = offset - otp_pkg::USER_FIRST_IDX;
            region = rel[7:4];
            writeMask = lockFirst[region] ? otp_pkg::ERASED_BYTE : 8'h00;
        end
        else if (offset == otp_pkg::LOCK_SECOND_IDX)
            writeMask = otp_pkg::ERASED_BYTE;
        else if (offset == otp_pkg::LOCK_SECOND_IDX + 9'h001)
            writeMask = otp_pkg::LOCK_SECOND_HI_MASK;
        else
        begin
            rel = offset - otp_pkg::USER_SECOND_IDX;
            region = rel[7:4];
            writeMask = lockSecond[region] ? otp_pkg::ERASED_BYTE : 8'h00;
        end
    end

endmodule // otp_region_map

// >>> src/pin_sync.sv
// Three-stage synchroniser with agreement filter for a group of pin inputs.
// Assumes the inputs are asynchronous to sys_clk; the output moves when stages two and three agree.
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
)(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Pins and filtered result
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinOut
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_t;

    sync_state_t st_reg;
    sync_state_t st_next;

    always_comb
    begin
        st_next = st_reg;
        st_next.s1 = pinIn;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        // Each bit follows only when the two later stages match.
        st_next.q = (st_reg.s2 & st_reg.s3) | (st_reg.q & (st_reg.s2 | st_reg.s3));
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            st_reg <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
        else
            st_reg <= st_next;
    end

    assign pinOut = st_reg.q;

endmodule // pin_sync

// >>> test/otp_region_access_props.sv
// Checker for the OTP block: bus answer timing, read data and serial enable.
// Assumes it is bound to otp_region_access and sees only its ports.
`timescale 1ns/1ns
module otp_region_access_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Watched ports
    input wire otp_pkg::spi_pins_t spiPins,
    input wire logic serialOut,
    input wire logic serialOutEn,
    input wire logic mainBusy,
    input wire otp_pkg::bus_req_t avs,
    input wire logic [31:0] avsReaddata,
    input wire logic avsWaitrequest
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_rdDone; avs.read && !avsWaitrequest; endsequence
    sequence s_stat; s_rdDone ##0 avs.address == otp_pkg::REG_STATUS; endsequence
    a_wait_one_cycle: assert property ((avs.read || avs.write) && avsWaitrequest
        |=> !avsWaitrequest) else $error("wait too long");
    a_unmapped_zero: assert property (s_rdDone ##0 avs.address[4] |-> avsReaddata == '0)
        else $error("unmapped read not zero");
    a_ctrl_reads_zero: assert property (s_rdDone ##0 avs.address == otp_pkg::REG_CTRL
        |-> avsReaddata == '0) else $error("control read not zero");
    a_busy_shown: assert property (s_stat ##0 $past(mainBusy) |-> avsReaddata[0])
        else $error("busy not shown");
    a_lock_fixed_bits: assert property (s_stat |-> avsReaddata[31:26] == 6'h3F)
        else $error("fixed lock bits changed");
    a_readdata_hold: assert property (!avs.read |=> $stable(avsReaddata))
        else $error("read data moved");
    a_out_idle: assert property (spiPins.csN [*6] |-> !serialOutEn)
        else $error("output driven while deselected");
    a_reset_quiet: assert property (disable iff (1'b0) !resetn |-> !serialOutEn && avsReaddata == '0)
        else $error("outputs active in reset");
endmodule // otp_region_access_props
bind otp_region_access otp_region_access_props u_props (.sys_clk(sys_clk), .resetn(resetn),
    .spiPins(spiPins), .serialOut(serialOut), .serialOutEn(serialOutEn), .mainBusy(mainBusy),
    .avs(avs), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest));

// >>> test/spi_host_model.sv
// Serial host model: frames mode-0 commands, MSB first, on the block's pins.
// Assumes sys_clk paces it; each SCLK phase lasts eight sys_clk cycles.
`timescale 1ns/1ns
module spi_host_model (
    // Clock and data from the block
    input wire logic sys_clk,
    input wire logic serialOut,
    input wire logic serialOutEn,
    // Pins to the block
    output otp_pkg::spi_pins_t pins
);
    initial pins = '{sclk: 1'b0, csN: 1'b1, si: 1'b0, hwResetN: 1'b1};
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            pins.si <= tx[i];
            repeat (8) @(posedge sys_clk);
            pins.sclk <= 1'b1;
            rx[i] = serialOutEn ? serialOut : !serialOut;
            repeat (8) @(posedge sys_clk);
            pins.sclk <= 1'b0;
        end
    endtask
    task automatic frame(input logic [7:0] op, input int nAdr, input logic [23:0] adr,
                         input int nTx, input logic [7:0] d, input int nRx, output logic [7:0] rx);
        logic [7:0] junk;
        pins.csN <= 1'b0;
        repeat (8) @(posedge sys_clk);
        xfer(op, junk);
        for (int i = nAdr - 1; i >= 0; i--)
            xfer(adr[8*i +: 8], junk);
        repeat (nTx) xfer(d, junk);
        repeat (nRx) xfer(~d, rx);
        repeat (8) @(posedge sys_clk);
        pins.csN <= 1'b1;
        pins.si <= ~pins.si;
        repeat (16) @(posedge sys_clk);
    endtask
endmodule // spi_host_model

// >>> test/tb.sv
// Self-checking bench for the OTP block over the register bus and the serial pins.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/1ns
module tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic mainBusy = 1'b0;
    otp_pkg::bus_req_t avs = '0;
    otp_pkg::spi_pins_t spiPins;
    logic serialOut, serialOutEn, avsWaitrequest;
    logic [31:0] avsReaddata, seed = 32'h0000_b8cb;
    logic [31:0] ser [2];
    logic [63:0] q[$], e;
    logic [7:0] rx, d;
    int n_errors = 0;
    int total_checks = 0;
    always #20 sys_clk = ~sys_clk;
    spi_host_model host (.sys_clk(sys_clk), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .pins(spiPins));
    otp_region_access dut (.sys_clk(sys_clk), .resetn(resetn), .spiPins(spiPins),
        .serialOut(serialOut), .serialOutEn(serialOutEn), .mainBusy(mainBusy), .avs(avs),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        total_checks++;
        if ((got & m) !== (exp & m))
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    always @(posedge sys_clk)
        if (avs.read && avsWaitrequest === 1'b0 && q.size() > 0)
        begin
            e = q.pop_front();
            chk(avsReaddata, e[63:32], e[31:0]);
        end
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                       input logic [63:0] em);
        int n = 0;
        if (!wr) q.push_back(em);
        avs <= '{address: a, read: !wr, write: wr, byteenable: 4'hF, writedata: wd};
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (avsWaitrequest !== 1'b0 && n < 20);
        avs.read <= 1'b0;
        avs.write <= 1'b0;
        @(posedge sys_clk);
        if (n >= 20) begin n_errors++; stop_test(); end
    endtask
    task automatic waitIdle();
        int n = 0;
        do
        begin
            host.frame(otp_pkg::OP_READ_STATUS, 0, 24'h0, 0, 8'h00, 1, rx);
            n++;
        end while (rx[0] !== 1'b0 && n < 400);
        if (n >= 400) begin n_errors++; stop_test(); end
    endtask
    task automatic prog(input logic [23:0] a, input logic [7:0] v, input int nd);
        host.frame(otp_pkg::OP_WRITE_ENABLE, 0, 24'h0, 0, 8'h00, 0, rx);
        host.frame(otp_pkg::OP_ONE_TIME_PROGRAM, 3, a, nd, v, 0, rx);
        waitIdle();
    endtask
    task automatic otpRead(input logic [23:0] a, input logic [7:0] x);
        host.frame(otp_pkg::OP_ONE_TIME_READ, 3, a, 1, 8'h00, 1, rx);
        chk({24'h0, rx}, {24'h0, x}, 32'h0000_00FF);
    endtask
    initial
    begin
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge sys_clk);
        ser[0] = rnd();
        ser[1] = rnd();
        d = 8'(rnd());
        bus(1'b1, otp_pkg::REG_SERIAL_LO, ser[0], '0);
        bus(1'b1, otp_pkg::REG_SERIAL_HI, ser[1], '0);
        bus(1'b0, otp_pkg::REG_SERIAL_LO, '0, {ser[0], 32'hFFFF_FFFF});
        bus(1'b0, otp_pkg::REG_CTRL, '0, {32'h0, 32'hFFFF_FFFF});
        bus(1'b0, 5'h10, '0, {32'h0, 32'hFFFF_FFFF});
        bus(1'b0, otp_pkg::REG_STATUS, '0, {32'hFF00_0000, 32'hFF00_0005});
        otpRead(24'h00_0102, 8'hFF);
        prog(24'h00_0114, d, 1);
        otpRead(24'h00_0114, d);
        prog(24'h00_0114, 8'h0F, 1);
        otpRead(24'h00_0114, d & 8'h0F);
        prog(24'h00_0115, 8'h00, 2);
        otpRead(24'h00_0115, 8'hFF);
        prog(24'h00_0112, 8'hFE, 1);
        prog(24'h00_0114, 8'h00, 1);
        otpRead(24'h00_0114, d & 8'h0F);
        prog(24'h00_0215, 8'h00, 1);
        otpRead(24'h00_0215, 8'h80);
        prog(24'h00_0100, 8'h01, 1);
        otpRead(24'h00_0100, 8'hFD);
        bus(1'b1, otp_pkg::REG_CTRL, 32'h0000_0001, '0);
        waitIdle();
        bus(1'b0, otp_pkg::REG_STATUS, '0, {32'hFC00_0000, 32'hFF00_0005});
        otpRead(24'h00_0102, ser[0][7:0]);
        mainBusy <= 1'b1;
        bus(1'b0, otp_pkg::REG_STATUS, '0, {32'h1, 32'h1});
        host.frame(otp_pkg::OP_ONE_TIME_READ, 3, 24'h00_0102, 1, 8'h00, 1, rx);
        mainBusy <= 1'b0;
        bus(1'b0, otp_pkg::REG_STATUS, '0, {32'h8, 32'h8});
        bus(1'b1, otp_pkg::REG_CTRL, 32'h0000_0002, '0);
        bus(1'b0, otp_pkg::REG_STATUS, '0, {32'h0, 32'h8});
        prog(24'h00_0324, 8'h00, 1);
        otpRead(24'h00_0124, 8'hFF);
        host.frame(otp_pkg::OP_ONE_TIME_READ, 3, 24'h00_0113, 1, 8'h00, 2, rx);
        chk({24'h0, rx}, {24'h0, d & 8'h0F}, 32'h0000_00FF);
        stop_test();
    end
endmodule // tb
